/* rtl/wwdt_regs.vh */
// constants and register map of the windowed watchdog timer
// Notes on behaviour
// - counter runs off the 31 kHz low-power oscillator, forced on while enabled
// - prescaler divides by 32 (5-bit) or by 128 (7-bit)
// - prescale_select one picks divide-by-128, zero picks divide-by-32
// - base period is nominally 1 ms or 4 ms at 31 kHz
// - four-bit postscaler further divides, 16 ratios from 1:1 to 1:32768
// - postscale code n gives ratio one to two to the n
// - counters clear on device reset, power-save entry or exit, and clear instruction
// - counters also clear when any clock switch completes
// - keeps counting in sleep and idle; time-out there wakes the device
// - sleep and idle status bits stay set until software clears them
// - time-out flag stays set until software writes it clear
// - in windowed mode a clear restarts the count, early or not; only one within the final quarter avoids a reset
// - in windowed mode an early clear causes a watchdog reset
// - window_disable zero selects windowed mode, one selects standard mode
// - fixed_watchdog_enable set means the watchdog always runs
// - fixed enable zero means it runs only while soft enable is set
// - any device reset forces soft_watchdog_enable to zero
`ifndef WWDT_REGS_VH
`define WWDT_REGS_VH

// register byte addresses
`define WWDT_ADDR_CONFIG 32'h0000_0000
`define WWDT_ADDR_RSTCTL 32'h0000_0004
`define WWDT_ADDR_COUNT 32'h0000_0008
`define WWDT_ADDR_STATUS 32'h0000_000C

// config_word_one fields and reset value (unprogrammed reads as ones)
`define WWDT_CFG_FIXED_EN 7
`define WWDT_CFG_WIN_DIS 6
`define WWDT_CFG_PRE_SEL 4
`define WWDT_CFG_RESET 8'hFF

// reset_control_reg fields
`define WWDT_RSTCTL_SOFT_EN 5
`define WWDT_RSTCTL_TIMEOUT 4
`define WWDT_RSTCTL_SLEEP 3
`define WWDT_RSTCTL_IDLE 2

// status register fields
`define WWDT_ST_RUNNING 0
`define WWDT_ST_WINDOW 1
`define WWDT_ST_PWRSAVE 2

// prescaler last counts: divide-by-32 and divide-by-128
`define WWDT_PRE_LAST_32 7'h1F
`define WWDT_PRE_LAST_128 7'h7F
`define WWDT_PRE_BITS_32 5'h05
`define WWDT_PRE_BITS_128 5'h07

// timing: system clock and nominal oscillator, in hertz
`define WWDT_CLK_HZ 100000000
`define WWDT_OSC_HZ 31000
`define WWDT_OSC_DIV ((`WWDT_CLK_HZ + `WWDT_OSC_HZ / 2) / `WWDT_OSC_HZ)

// bus responses
`define WWDT_RESP_OKAY 2'h0
`define WWDT_RESP_SLVERR 2'h2

`endif

/* rtl/wwdt_low_power_rc_osc_tick.v */
// low-power oscillator model: one-cycle tick at the nominal rate
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_regs.vh"

module wwdt_osc_tick (
    // clock and reset
    input wire clk_sys,
    input wire reset,
    // oscillator control and output
    input wire osc_on,
    output reg tick
);

// full-width count, cut to the divider width on purpose
localparam [31:0] DIV_LAST_W = `WWDT_OSC_DIV - 1;
localparam [11:0] DIV_LAST = DIV_LAST_W[11:0];

reg [11:0] phase;

// divider stops and restarts from zero while the oscillator is off
always @(posedge clk_sys) begin
    if (reset || !osc_on) begin
        phase <= 12'h000;
        tick <= 1'b0;
    end else if (phase == DIV_LAST) begin
        phase <= 12'h000;
        tick <= 1'b1;
    end else begin
        phase <= phase + 12'h001;
        tick <= 1'b0;
    end
end

endmodule // wwdt_osc_tick
`default_nettype wire

/* rtl/wwdt_top.v */
// windowed watchdog timer with an AXI4-Lite register slave
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_regs.vh"

module wwdt_top (
    // clock and reset
    input wire clk_sys,
    input wire reset,
    // axi4-lite write address
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // processor core events, one-cycle pulses
    input wire device_reset,
    input wire watchdog_clear_instr,
    input wire power_save_instr,
    input wire power_save_sleep,
    input wire power_save_exit,
    input wire clock_switch_done,
    // watchdog outputs
    output reg wdt_reset_req,
    output reg wake_req,
    output wire low_power_rc_osc_on,
    output wire wdt_running
);

////////////////////////////////////////////////////////////////////////////////
// register state

reg [7:0] config_word_one;
reg soft_watchdog_enable;
reg timeout_flag;
reg sleep_flag;
reg idle_flag;
reg in_power_save;
reg [6:0] prescale_count;
reg [14:0] postscale_count;

wire fixed_watchdog_enable = config_word_one[`WWDT_CFG_FIXED_EN];
wire window_disable = config_word_one[`WWDT_CFG_WIN_DIS];
wire prescale_select = config_word_one[`WWDT_CFG_PRE_SEL];
wire [3:0] postscale_select = config_word_one[3:0];

////////////////////////////////////////////////////////////////////////////////
// enable and oscillator

// fixed enable overrides, otherwise software decides
assign wdt_running = fixed_watchdog_enable | soft_watchdog_enable;
assign low_power_rc_osc_on = wdt_running;

wire osc_tick;

wwdt_osc_tick u_tick (
    .clk_sys(clk_sys),
    .reset(reset),
    .osc_on(low_power_rc_osc_on),
    .tick(osc_tick)
);

////////////////////////////////////////////////////////////////////////////////
// period decode

// mask of the last postscaler count for code n: two to the n, minus one
function [14:0] post_last;
    input [3:0] code;
    begin
        post_last = (15'h0001 << code) - 15'h0001;
    end
endfunction

// length of the whole period in ticks, as a power of two
function [4:0] period_bits;
    input sel;
    input [3:0] code;
    begin
        period_bits = (sel ? `WWDT_PRE_BITS_128 : `WWDT_PRE_BITS_32) + {1'b0, code};
    end
endfunction

wire [6:0] pre_last_val = prescale_select ? `WWDT_PRE_LAST_128 : `WWDT_PRE_LAST_32;
wire pre_last = (prescale_count == pre_last_val);
wire post_last_hit = (postscale_count == post_last(postscale_select));

// combined position inside the period
wire [21:0] period_pos = prescale_select ? {postscale_count, prescale_count}
                                         : {2'b00, postscale_count, prescale_count[4:0]};
wire [4:0] k_bits = period_bits(prescale_select, postscale_select);
// one bit wider so that the longest period, two to the 22, does not wrap to zero
wire [22:0] period_len = 23'h00_0001 << k_bits;
wire [22:0] window_start = period_len - (period_len >> 2);
wire in_window = ({1'b0, period_pos} >= window_start);

////////////////////////////////////////////////////////////////////////////////
// events

wire windowed = ~window_disable;

// clear honoured only in normal running and, when windowed, inside the window
wire clr_normal = watchdog_clear_instr & ~in_power_save;
wire clr_early = clr_normal & wdt_running & windowed & ~in_window;
wire clr_ok = clr_normal & ~(windowed & ~in_window);

// a clear in the tick cycle voids that tick, so no request follows a restart
wire clear_event = device_reset | clr_normal | power_save_instr | power_save_exit | clock_switch_done;
wire timeout = wdt_running & osc_tick & pre_last & post_last_hit & ~clear_event;

wire to_wake = timeout & in_power_save;
wire to_reset = (timeout & ~in_power_save) | clr_early;

// every source that restarts the count
wire count_clear = device_reset | clr_ok | clr_early | power_save_instr
    | power_save_exit | to_wake | clock_switch_done;

////////////////////////////////////////////////////////////////////////////////
// counters

// clear beats increment; disabled watchdog holds zero
always @(posedge clk_sys) begin
    if (reset || count_clear || !wdt_running) begin
        prescale_count <= 7'h00;
        postscale_count <= 15'h0000;
    end else if (osc_tick) begin
        if (pre_last) begin
            prescale_count <= 7'h00;
            postscale_count <= post_last_hit ? 15'h0000 : postscale_count + 15'h0001;
        end else begin
            prescale_count <= prescale_count + 7'h01;
        end
    end
end

// power-save tracking and core-facing pulses
always @(posedge clk_sys) begin
    if (reset || device_reset) begin
        in_power_save <= 1'b0;
        wdt_reset_req <= 1'b0;
        wake_req <= 1'b0;
    end else begin
        if (power_save_exit || to_wake) begin
            in_power_save <= 1'b0;
        end else if (power_save_instr) begin
            in_power_save <= 1'b1;
        end
        wdt_reset_req <= to_reset;
        wake_req <= to_wake;
    end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write path

reg aw_full;
reg [31:0] aw_addr;
reg w_full;
reg [31:0] w_data;
reg [3:0] w_strb;

assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
assign s_axi_wready = ~w_full & ~s_axi_bvalid;

wire wr_fire = aw_full & w_full & ~s_axi_bvalid;
wire wr_cfg = wr_fire & (aw_addr == `WWDT_ADDR_CONFIG) & w_strb[0];
wire wr_rstctl = wr_fire & (aw_addr == `WWDT_ADDR_RSTCTL) & w_strb[0];
wire wr_known = (aw_addr == `WWDT_ADDR_CONFIG) | (aw_addr == `WWDT_ADDR_RSTCTL)
    | (aw_addr == `WWDT_ADDR_COUNT) | (aw_addr == `WWDT_ADDR_STATUS);

// address and data are latched independently, in either order
always @(posedge clk_sys) begin
    if (reset) begin
        aw_full <= 1'b0;
        aw_addr <= 32'h0000_0000;
        w_full <= 1'b0;
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `WWDT_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
            aw_addr <= {s_axi_awaddr[31:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// control and status bits

// write-zero clears; a hardware set in the same cycle wins
wire clr_to = wr_rstctl & ~w_data[`WWDT_RSTCTL_TIMEOUT];
wire clr_sl = wr_rstctl & ~w_data[`WWDT_RSTCTL_SLEEP];
wire clr_id = wr_rstctl & ~w_data[`WWDT_RSTCTL_IDLE];
wire set_sl = power_save_instr & power_save_sleep;
wire set_id = power_save_instr & ~power_save_sleep;

always @(posedge clk_sys) begin
    if (reset) begin
        config_word_one <= `WWDT_CFG_RESET;
        timeout_flag <= 1'b0;
        sleep_flag <= 1'b0;
        idle_flag <= 1'b0;
    end else begin
        if (wr_cfg) begin
            config_word_one <= w_data[7:0] | 8'h20; // unimplemented bit reads as one
        end
        timeout_flag <= to_reset | (timeout_flag & ~clr_to);
        sleep_flag <= set_sl | (sleep_flag & ~clr_sl);
        idle_flag <= set_id | (idle_flag & ~clr_id);
    end
end

// software enable, forced off by any device reset
always @(posedge clk_sys) begin
    if (reset || device_reset) begin
        soft_watchdog_enable <= 1'b0;
    end else if (wr_rstctl) begin
        soft_watchdog_enable <= w_data[`WWDT_RSTCTL_SOFT_EN];
    end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read path

assign s_axi_arready = ~s_axi_rvalid;

reg [31:0] next_rdata;
reg [1:0] next_rresp;
wire [31:0] ar_addr = {s_axi_araddr[31:2], 2'b00};

// read mux; unmapped addresses read zero with an error
always @* begin
    next_rdata = 32'h0000_0000;
    next_rresp = `WWDT_RESP_OKAY;
    case (ar_addr)
        `WWDT_ADDR_CONFIG: begin
            next_rdata[7:0] = config_word_one;
        end
        `WWDT_ADDR_RSTCTL: begin
            next_rdata[`WWDT_RSTCTL_SOFT_EN] = soft_watchdog_enable;
            next_rdata[`WWDT_RSTCTL_TIMEOUT] = timeout_flag;
            next_rdata[`WWDT_RSTCTL_SLEEP] = sleep_flag;
            next_rdata[`WWDT_RSTCTL_IDLE] = idle_flag;
        end
        `WWDT_ADDR_COUNT: begin
            next_rdata[21:0] = period_pos;
        end
        `WWDT_ADDR_STATUS: begin
            next_rdata[`WWDT_ST_RUNNING] = wdt_running;
            next_rdata[`WWDT_ST_WINDOW] = in_window;
            next_rdata[`WWDT_ST_PWRSAVE] = in_power_save;
        end
        default: begin
            next_rresp = `WWDT_RESP_SLVERR;
        end
    endcase
end

// read answer one cycle after the address is taken
always @(posedge clk_sys) begin
    if (reset) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `WWDT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule // wwdt_top
`default_nettype wire

/* tb/wwdt_top_chk.sv */
// assertion checker for the windowed watchdog top level
`timescale 1ns/1ps
`default_nettype none
module wwdt_top_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // core events
    input wire logic device_reset,
    input wire logic watchdog_clear_instr,
    input wire logic power_save_instr,
    input wire logic clock_switch_done,
    // watchdog outputs
    input wire logic wdt_reset_req,
    input wire logic wake_req,
    input wire logic low_power_rc_osc_on,
    input wire logic wdt_running
);
    localparam int MIN_GAP = 31 * 3226;
    logic [19:0] since_clr;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    // cycles since a sure counter clear, saturating; missing a clear only makes it larger
    always @(posedge clk_sys) begin
        if (reset || device_reset || power_save_instr || clock_switch_done)
            since_clr <= 20'h0_0000;
        else if (since_clr != 20'hF_FFFF)
            since_clr <= since_clr + 20'h0_0001;
    end
    ////////////////////////////////////////////////////////////////
    osc_follows_run_a: assert property (low_power_rc_osc_on == wdt_running)
        else $error("oscillator enable differs from running state");
    reset_min_gap_a: assert property (wdt_reset_req && !$past(watchdog_clear_instr)
        |-> since_clr >= MIN_GAP)
        else $error("reset request before a full base period");
    wake_min_gap_a: assert property (wake_req |-> since_clr >= MIN_GAP)
        else $error("wake request before a full base period");
    reset_one_cycle_a: assert property (wdt_reset_req |=> !wdt_reset_req)
        else $error("reset request longer than one cycle");
    wake_one_cycle_a: assert property (wake_req |=> !wake_req)
        else $error("wake request longer than one cycle");
    wake_or_reset_a: assert property (!(wake_req && wdt_reset_req))
        else $error("wake and reset requested together");
    dev_reset_quiet_a: assert property (device_reset && !watchdog_clear_instr
        |=> !wdt_reset_req && !wake_req)
        else $error("request right after device reset");
    switch_quiet_a: assert property (clock_switch_done && !watchdog_clear_instr
        |=> !wdt_reset_req && !wake_req)
        else $error("request right after clock switch");
    save_entry_quiet_a: assert property (power_save_instr |=> !wake_req && !wdt_reset_req)
        else $error("request right after power save entry");
    cover property (wdt_reset_req);
    cover property (wake_req);
    cover property ($fell(wdt_running));
endmodule // wwdt_top_chk
bind wwdt_top wwdt_top_chk chk (.clk_sys(clk_sys), .reset(reset), .device_reset(device_reset),
    .watchdog_clear_instr(watchdog_clear_instr), .power_save_instr(power_save_instr),
    .clock_switch_done(clock_switch_done), .wdt_reset_req(wdt_reset_req), .wake_req(wake_req),
    .low_power_rc_osc_on(low_power_rc_osc_on), .wdt_running(wdt_running));
`default_nettype wire

/* tb/wwdt_core_model.sv */
// processor core model issuing instruction and event pulses
`timescale 1ns/1ps
`default_nettype none
module wwdt_core_model (
    // clock
    input wire logic clk_sys,
    // watchdog requests
    input wire logic wdt_reset_req,
    // instruction and event pulses
    output logic device_reset,
    output logic watchdog_clear_instr,
    output logic power_save_instr,
    output logic power_save_sleep,
    output logic power_save_exit,
    output logic clock_switch_done
);
    int lag = 4;
    int wait_n = -1;
    initial begin
        {device_reset, watchdog_clear_instr, power_save_instr} = 3'h0;
        {power_save_sleep, power_save_exit, clock_switch_done} = 3'h0;
    end
    // a reset request comes back as a device reset lag plus one cycles after it is seen; wait_n of 0 resets at once
    always @(posedge clk_sys) begin
        device_reset <= 1'b0;
        if (wdt_reset_req) begin
            wait_n <= lag;
        end else if (wait_n == 0) begin
            device_reset <= 1'b1;
            wait_n <= -1;
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end
    end
    // one event pulse: 0 clear, 1 power save, 2 exit, 3 clock switch done
    task automatic issue(input int k, input logic sleep);
        @(posedge clk_sys);
        watchdog_clear_instr <= (k == 0);
        power_save_instr <= (k == 1);
        power_save_sleep <= sleep;
        power_save_exit <= (k == 2);
        clock_switch_done <= (k == 3);
        @(posedge clk_sys);
        {watchdog_clear_instr, power_save_instr, power_save_exit, clock_switch_done} <= 4'h0;
    endtask
endmodule // wwdt_core_model
`default_nettype wire

/* tb/test_windowed_watchdog_timer.sv */
// self-checking testbench for the windowed watchdog top level
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_regs.vh"
module test_windowed_watchdog_timer;
    typedef struct {logic wr; logic [31:0] addr; logic [31:0] data; logic [1:0] resp;} wwdt_row_t;
    localparam int TICK = 3226;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rdata;
    logic device_reset, watchdog_clear_instr, power_save_instr, power_save_sleep, power_save_exit;
    logic clock_switch_done, wdt_reset_req, wake_req, low_power_rc_osc_on, wdt_running;
    int mismatches = 0;
    int checked = 0;
    int n;
    wwdt_row_t rows [10] = '{
        '{1'b0, `WWDT_ADDR_CONFIG, 32'h0000_00FF, `WWDT_RESP_OKAY},
        '{1'b0, `WWDT_ADDR_RSTCTL, 32'h0000_0000, `WWDT_RESP_OKAY},
        '{1'b0, `WWDT_ADDR_STATUS, 32'h0000_0001, `WWDT_RESP_OKAY},
        '{1'b1, `WWDT_ADDR_CONFIG, 32'h0000_0050, `WWDT_RESP_OKAY},
        '{1'b0, `WWDT_ADDR_CONFIG, 32'h0000_0070, `WWDT_RESP_OKAY},
        '{1'b0, `WWDT_ADDR_STATUS, 32'h0000_0000, `WWDT_RESP_OKAY},
        '{1'b1, `WWDT_ADDR_RSTCTL, 32'h0000_0020, `WWDT_RESP_OKAY},
        '{1'b0, `WWDT_ADDR_STATUS, 32'h0000_0001, `WWDT_RESP_OKAY},
        '{1'b1, 32'h0000_0010, 32'h0000_0000, `WWDT_RESP_SLVERR},
        '{1'b0, 32'h0000_0010, 32'h0000_0000, `WWDT_RESP_SLVERR}};
    always #5 clk_sys = ~clk_sys;
    wwdt_top uut (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .device_reset(device_reset), .watchdog_clear_instr(watchdog_clear_instr), .power_save_instr(power_save_instr),
        .power_save_sleep(power_save_sleep), .power_save_exit(power_save_exit), .clock_switch_done(clock_switch_done),
        .wdt_reset_req(wdt_reset_req), .wake_req(wake_req), .low_power_rc_osc_on(low_power_rc_osc_on),
        .wdt_running(wdt_running));
    wwdt_core_model core (.clk_sys(clk_sys), .wdt_reset_req(wdt_reset_req), .device_reset(device_reset),
        .watchdog_clear_instr(watchdog_clear_instr), .power_save_instr(power_save_instr),
        .power_save_sleep(power_save_sleep), .power_save_exit(power_save_exit), .clock_switch_done(clock_switch_done));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // bus write: address and data offered together, each released once taken
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // bus read
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // count cycles until the chosen request shows, up to a limit
    task automatic wait_req(input logic wake, input int limit, output int cnt);
        cnt = 0;
        while (cnt < limit && (wake ? wake_req : wdt_reset_req) !== 1'b1) begin
            @(posedge clk_sys);
            cnt++;
        end
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_write(rows[i].addr, rows[i].data, resp);
            end else begin
                axi_read(rows[i].addr, rdata, resp);
                check("rdata", rdata, rows[i].data);
            end
            check("resp", 32'(resp), 32'(rows[i].resp));
        end
        // prompt device reset drops the software enable
        core.wait_n <= 0;
        repeat (3) @(posedge clk_sys);
        check("running", 32'(wdt_running), 32'h0000_0000);
        check("osc_on", 32'(low_power_rc_osc_on), 32'h0000_0000);
        // windowed mode with fixed enable, clear far too early
        axi_write(`WWDT_ADDR_CONFIG, 32'h0000_0080, resp);
        axi_read(`WWDT_ADDR_CONFIG, rdata, resp);
        check("config", rdata, 32'h0000_00A0);
        core.issue(0, 1'b0);
        wait_req(1'b0, 8, n);
        check("early_clear", 32'(n < 8), 32'h0000_0001);
        repeat (10) @(posedge clk_sys);
        axi_read(`WWDT_ADDR_RSTCTL, rdata, resp);
        check("flag", rdata, 32'h0000_0010);
        core.issue(3, 1'b0);
        axi_write(`WWDT_ADDR_RSTCTL, 32'h0000_0000, resp);
        axi_read(`WWDT_ADDR_RSTCTL, rdata, resp);
        check("flag_clr", rdata, 32'h0000_0000);
        // standard mode: an early clear only restarts the count
        axi_write(`WWDT_ADDR_CONFIG, 32'h0000_00C0, resp);
        core.issue(0, 1'b0);
        wait_req(1'b0, 8, n);
        check("std_clear", 32'(n == 8), 32'h0000_0001);
        // windowed, divide by 32, ratio 1:1: window opens during sleep, then the time-out wakes
        axi_write(`WWDT_ADDR_CONFIG, 32'h0000_0080, resp);
        core.issue(1, 1'b1);
        axi_read(`WWDT_ADDR_STATUS, rdata, resp);
        check("status", rdata, 32'h0000_0005);
        repeat (25 * TICK) @(posedge clk_sys);
        axi_read(`WWDT_ADDR_STATUS, rdata, resp);
        check("window", rdata, 32'h0000_0007);
        wait_req(1'b1, 8 * TICK, n);
        check("wake", 32'(n > 6 * TICK - 20 && n <= 7 * TICK), 32'h0000_0001);
        axi_read(`WWDT_ADDR_RSTCTL, rdata, resp);
        check("sleep_bit", rdata, 32'h0000_0008);
        axi_write(`WWDT_ADDR_RSTCTL, 32'h0000_0000, resp);
        axi_read(`WWDT_ADDR_RSTCTL, rdata, resp);
        check("sleep_clr", rdata, 32'h0000_0000);
        // idle entry, then an exit by another cause
        core.issue(1, 1'b0);
        core.issue(2, 1'b0);
        axi_read(`WWDT_ADDR_RSTCTL, rdata, resp);
        check("idle_bit", rdata, 32'h0000_0004);
        axi_read(`WWDT_ADDR_STATUS, rdata, resp);
        check("exit", rdata, 32'h0000_0001);
        end_of_test();
    end
    // watchdog against a hang
    initial begin
        repeat (110000) @(posedge clk_sys);
        mismatches++;
        end_of_test();
    end
endmodule // test_windowed_watchdog_timer
`default_nettype wire
